// file: core/pcc_pkg.sv
// Purpose: constants for the configuration front portion (identity and command word)
// Assumes: config accesses arrive as dword-indexed reads and writes on the bus clock
// Notes:   command bits not listed as writable read back as zero
// ====================================================================
package pcc_pkg;
    // ================================================================
    // register map, dword index into config space
    localparam logic [5:0]  CFG_IDENT_IDX   = 6'h00;  // device_ident : vendor_ident
    localparam logic [5:0]  CFG_CMD_IDX     = 6'h01;  // status (zero here) : pci_command

    // ================================================================
    // command word fields
    localparam int          CMD_IO_BIT      = 0;
    localparam int          CMD_MEM_BIT     = 1;
    localparam int          CMD_MASTER_BIT  = 2;
    localparam int          CMD_MWI_BIT     = 4;
    localparam int          CMD_PERR_BIT    = 6;
    localparam int          CMD_SERR_BIT    = 8;
    localparam int          CMD_FBB_BIT     = 9;
    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic [15:0] CMD_RW_MASK     = 16'h0157;  // bits 8,6,4,2,1,0
    localparam logic [15:0] CMD_FBB_MASK    = 16'h0200;

    // ================================================================
    // identity defaults when no EEPROM answers; values are arbitrary
    localparam logic [15:0] VENDOR_DEFAULT  = 16'h1d0a;
    localparam logic [15:0] DEVICE_DEFAULT  = 16'h0c31;
endpackage : pcc_pkg

// file: core/pcc_cfg_front.sv
// Purpose: identity fields and command register of the config space front portion
// Assumes: one clock (the bus clock), synchronous active-high reset, same-clock request logic
// Notes:   SERR# and PERR# leave as out/oe_n pairs; the bench resolves the PERR# wire
`timescale 1ns/100ps
module pcc_cfg_front
    import pcc_pkg::*;
#(
    parameter logic [15:0] VENDOR_DFLT = pcc_pkg::VENDOR_DEFAULT,  // arbitrary value
    parameter logic [15:0] DEVICE_DFLT = pcc_pkg::DEVICE_DEFAULT   // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        srst,
    // config access port
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [5:0]  cfg_idx,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    // identity load from the EEPROM loader
    input  wire logic        ee_load_stb,
    input  wire logic        ee_present,
    input  wire logic [15:0] ee_vendor,
    input  wire logic [15:0] ee_device,
    // option bit from config_reg_three
    input  wire logic        fbb_option,
    // bus side events
    input  wire logic        addr_parity_err,
    input  wire logic        target_data_parity_err,
    input  wire logic        master_active,
    input  wire logic        special_cycle_seen,
    input  wire logic        master_want,
    input  wire logic        perr_n_in,
    output logic             perr_n_out,
    output logic             perr_oe_n,
    output logic             serr_n_out,
    output logic             serr_oe_n,
    // gates to the rest of the controller
    output logic             io_space_enable,
    output logic             memory_space_enable,
    output logic             master_req,
    output logic             write_invalidate_enable,
    output logic             fbb_diff_agent,
    output logic             master_perr_seen,
    output logic             special_cycle_claim,
    output logic             addr_data_stepping
);
    import pcc_pkg::*;

    // ================================================================
    // state
    logic [15:0] vendor_q, device_q, cmd_q, cmd_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q;
    logic        perr_s1_q, perr_s2_q, perr_s3_q, perr_lvl_q;
    logic        perr_drv_q, serr_drv_q, mperr_q;
    logic        io_q, mem_q, mreq_q, mwi_q, fbb_q, sc_q, step_q;

    // ================================================================
    // helpers
    // one byte lane of a command write, shared by both lanes
    function automatic logic lane_write(input logic wr, input logic hit, input logic be_bit);
        return wr & hit & be_bit;
    endfunction

    // ================================================================
    // decode
    wire         cmd_hit     = cfg_idx == CFG_CMD_IDX;
    wire         id_hit      = cfg_idx == CFG_IDENT_IDX;
    wire         cmd_wr_lo   = lane_write(cfg_wr, cmd_hit, cfg_be[0]);
    wire         cmd_wr_hi   = lane_write(cfg_wr, cmd_hit, cfg_be[1]);
    wire  [15:0] lane_mask   = {{8{cmd_wr_hi}}, {8{cmd_wr_lo}}};
    // bit 9 keeps its storage while the option is off; reads and the gate mask it
    // fbb write gate
    wire  [15:0] fbb_wmask   = fbb_option ? CMD_FBB_MASK : 16'h0000;
    wire  [15:0] wr_mask     = (CMD_RW_MASK | fbb_wmask) & lane_mask;
    wire  [15:0] cmd_view    = cmd_q & (CMD_RW_MASK | fbb_wmask);

    // snoop, stepping and special bits have no storage
    assign cmd_d = (cmd_q & ~wr_mask) | (cfg_wdata[15:0] & wr_mask);

    // read mux, unmapped dwords read zero
    assign rdata_d = id_hit  ? {device_q, vendor_q} :
                     cmd_hit ? {16'h0000, cmd_view} : 32'h0000_0000;

    // ================================================================
    // identity fields
    // a load with no EEPROM falls back, so a failed read never leaves junk
    // vendor and device from EEPROM or default
    always_ff @(posedge clk) begin
        if (srst) begin
            vendor_q <= VENDOR_DFLT;
            device_q <= DEVICE_DFLT;
        end else if (ee_load_stb) begin
            vendor_q <= ee_present ? ee_vendor : VENDOR_DFLT;
            device_q <= ee_present ? ee_device : DEVICE_DFLT;
        end
    end

    // ================================================================
    // command word and access answer
    // enables reset to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q   <= CMD_RESET;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            cmd_q   <= cmd_d;
            ack_q   <= cfg_rd | cfg_wr;
            rdata_q <= cfg_rd ? rdata_d : 32'h0000_0000;  // zero between reads
        end
    end

    // ================================================================
    // PERR# input sync; a change counts once stages two and three agree
    // stage one may sit metastable, so it feeds nothing but stage two
    always_ff @(posedge clk) begin
        if (srst) begin
            perr_s1_q  <= 1'b1;
            perr_s2_q  <= 1'b1;
            perr_s3_q  <= 1'b1;
            perr_lvl_q <= 1'b1;
        end else begin
            perr_s1_q  <= perr_n_in;
            perr_s2_q  <= perr_s1_q;
            perr_s3_q  <= perr_s2_q;
            if (perr_s2_q == perr_s3_q) begin
                perr_lvl_q <= perr_s3_q;
            end
        end
    end

    // ================================================================
    // error pins: one-cycle low drive per detected error
    // a held error keeps the pin low; the detector must pulse per event
    always_ff @(posedge clk) begin
        if (srst) begin
            serr_drv_q <= 1'b0;
            perr_drv_q <= 1'b0;
            mperr_q    <= 1'b0;
        end else begin
            serr_drv_q <= addr_parity_err & cmd_q[CMD_SERR_BIT];
            perr_drv_q <= target_data_parity_err & cmd_q[CMD_PERR_BIT];
            mperr_q    <= master_active & ~perr_lvl_q & cmd_q[CMD_PERR_BIT];
        end
    end

    // ================================================================
    // gates toward target decode and master engine
    always_ff @(posedge clk) begin
        if (srst) begin
            io_q   <= 1'b0;
            mem_q  <= 1'b0;
            mreq_q <= 1'b0;
            mwi_q  <= 1'b0;
            fbb_q  <= 1'b0;
            sc_q   <= 1'b0;
            step_q <= 1'b0;
        end else begin
            io_q   <= cmd_q[CMD_IO_BIT];
            mem_q  <= cmd_q[CMD_MEM_BIT];
            mreq_q <= master_want & cmd_q[CMD_MASTER_BIT];
            mwi_q  <= cmd_q[CMD_MWI_BIT];
            fbb_q  <= fbb_option & cmd_q[CMD_FBB_BIT];
            sc_q   <= special_cycle_seen & 1'b0;
            step_q <= 1'b0;
        end
    end

    // ================================================================
    // outputs straight from flops, except serr_n_out and perr_n_out, which are tied low
    assign cfg_ack                 = ack_q;
    assign cfg_rdata               = rdata_q;
    assign serr_n_out              = 1'b0;          // open drain: only ever pulls low
    assign serr_oe_n               = ~serr_drv_q;
    assign perr_n_out              = 1'b0;
    assign perr_oe_n               = ~perr_drv_q;
    assign io_space_enable         = io_q;
    assign memory_space_enable     = mem_q;
    assign master_req              = mreq_q;
    assign write_invalidate_enable = mwi_q;
    assign fbb_diff_agent          = fbb_q;
    assign master_perr_seen        = mperr_q;
    assign special_cycle_claim     = sc_q;
    assign addr_data_stepping      = step_q;

    // ================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_fbb_locked_read: assert property (
        cfg_rd && cmd_hit && !fbb_option |=> cfg_rdata[CMD_FBB_BIT] == 1'b0)
        else $error("fbb bit read as one while option clear");
    a_fbb_write_kept: assert property (
        cfg_wr && cmd_hit && cfg_be[1] && fbb_option ##1 fbb_option
        |=> fbb_diff_agent == $past(cfg_wdata[CMD_FBB_BIT], 2))
        else $error("fbb write not reflected");
    a_serr_on_parity: assert property (
        addr_parity_err && cmd_q[CMD_SERR_BIT] |=> !serr_oe_n)
        else $error("serr not driven on address parity error");
    a_serr_quiet: assert property (
        !$past(cmd_q[CMD_SERR_BIT]) |-> serr_oe_n)
        else $error("serr driven while disabled");
    a_high_bits_zero: assert property (
        cfg_ack && $past(cfg_rd && cmd_hit) |-> cfg_rdata[31:10] == 22'h0 && cfg_rdata[7] == 1'b0
                    && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0)
        else $error("hardwired command bits read nonzero");
    a_perr_gated: assert property (
        target_data_parity_err |=> perr_oe_n == !$past(cmd_q[CMD_PERR_BIT]))
        else $error("perr drive not tied to response bit");
    a_master_gate: assert property (
        master_req |-> $past(cmd_q[CMD_MASTER_BIT]) && $past(master_want))
        else $error("master request without enable");
    a_io_follows: assert property (
        cfg_wr && cmd_hit && cfg_be[0] |-> ##2 io_space_enable == $past(cfg_wdata[0], 2))
        else $error("io enable did not follow write");
    a_mem_follows: assert property (
        cfg_wr && cmd_hit && cfg_be[0] |-> ##2 memory_space_enable == $past(cfg_wdata[1], 2))
        else $error("memory enable did not follow write");
    a_mwi_follows: assert property (
        cfg_wr && cmd_hit && cfg_be[0] |-> ##2 write_invalidate_enable == $past(cfg_wdata[4], 2))
        else $error("write invalidate enable did not follow write");
    a_no_special: assert property (
        special_cycle_seen |=> !special_cycle_claim && !addr_data_stepping)
        else $error("special cycle claimed or stepping seen");
    a_ident_load: assert property (
        ee_load_stb && !ee_present |=> vendor_q == VENDOR_DFLT && device_q == DEVICE_DFLT)
        else $error("identity not defaulted without eeprom");

    a_ident_eeprom: assert property (
        ee_load_stb && ee_present
        |=> vendor_q == $past(ee_vendor) && device_q == $past(ee_device))
        else $error("identity not taken from eeprom");
    a_fbb_read_open: assert property (
        cfg_rd && cmd_hit && fbb_option |=> cfg_rdata[CMD_FBB_BIT] == $past(cmd_q[CMD_FBB_BIT]))
        else $error("fbb bit not readable while option set");
    a_fbb_gate_off: assert property (
        !fbb_option |=> !fbb_diff_agent)
        else $error("fbb to other agents while option clear");
    a_perr_quiet: assert property (
        !$past(cmd_q[CMD_PERR_BIT]) |-> perr_oe_n)
        else $error("perr driven while response off");
    a_mperr_gated: assert property (
        master_perr_seen |-> $past(cmd_q[CMD_PERR_BIT]) && $past(master_active))
        else $error("master perr seen while response off");
    a_cmd_after_reset: assert property (
        $past(srst) |-> cmd_q == CMD_RESET)
        else $error("command word not cleared by reset");
    a_gates_after_reset: assert property (
        $past(srst) |-> !io_space_enable && !memory_space_enable && !master_req
                        && !write_invalidate_enable && !fbb_diff_agent)
        else $error("gates not cleared by reset");
    a_unmapped_zero: assert property (
        cfg_ack && $past(cfg_rd && !cmd_hit && !id_hit) |-> cfg_rdata == 32'h0000_0000)
        else $error("unmapped dword read nonzero");
    a_reserved_clear: assert property (
        cfg_wr && cmd_hit |=> (cmd_q & ~(CMD_RW_MASK | CMD_FBB_MASK)) == 16'h0000)
        else $error("reserved command bit stored");

    // ================================================================
    // main scenarios seen
    c_cmd_write: cover property (cfg_wr && cmd_hit ##1 cfg_ack);
    c_serr_fire: cover property (!serr_oe_n);
    c_master_perr: cover property (master_perr_seen);
    c_fbb_open: cover property (fbb_diff_agent);
    c_ident_eeprom: cover property (ee_load_stb && ee_present);
endmodule // pcc_cfg_front

// file: verification/pcc_host_model.sv
// Purpose: far-side PCI agent, resolves the PERR# wire shared with the block
// Assumes: wire has a pull-up; the block drives low only while its enable is low
// Notes:   the bench asks the model to pull PERR# low as another agent would
`timescale 1ns/100ps
module pcc_host_model (
    input  wire logic perr_n_out,
    input  wire logic perr_oe_n,
    input  wire logic host_perr_low,
    output logic      perr_wire
);
    // ================================================================
    // wired-and with pull-up, so a released wire reads high
    assign perr_wire = (perr_oe_n | perr_n_out) & ~host_perr_low;
endmodule // pcc_host_model

// file: verification/testbench.sv
// Purpose: directed checks of identity fields and command word behaviour
// Assumes: config port answers one cycle after each request
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module testbench;
    import pcc_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0, ld = 1'b0, eep = 1'b0;
    logic        fbb = 1'b0, ape = 1'b0, tpe = 1'b0, mact = 1'b0, scs = 1'b0, mw = 1'b1;
    logic        hlow = 1'b0, perr_w, p_out, p_oe, s_out, s_oe, ack;
    logic        ioe, meme, mreq, wie, fbbd, mps, scc, ads;
    logic [5:0]  idx = 6'h00;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [15:0] eev = 16'h0, eed = 16'h0;
    int          failures = 0, checks = 0, cycles = 0;

    pcc_cfg_front u_pcc_cfg_front (.clk(clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_idx(idx), .cfg_be(be), .cfg_wdata(wd), .cfg_ack(ack), .cfg_rdata(rdat),
        .ee_load_stb(ld), .ee_present(eep), .ee_vendor(eev), .ee_device(eed),
        .fbb_option(fbb), .addr_parity_err(ape), .target_data_parity_err(tpe),
        .master_active(mact), .special_cycle_seen(scs), .master_want(mw), .perr_n_in(perr_w),
        .perr_n_out(p_out), .perr_oe_n(p_oe), .serr_n_out(s_out), .serr_oe_n(s_oe),
        .io_space_enable(ioe), .memory_space_enable(meme), .master_req(mreq),
        .write_invalidate_enable(wie), .fbb_diff_agent(fbbd), .master_perr_seen(mps),
        .special_cycle_claim(scc), .addr_data_stepping(ads));

    pcc_host_model u_pcc_host_model (.perr_n_out(p_out), .perr_oe_n(p_oe),
        .host_perr_low(hlow), .perr_wire(perr_w));

    // ================================================================
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            results();
        end
    end

    // ================================================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access; ack must stand in the cycle after the request
    task acc(input logic w, input logic [5:0] i, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        #1;
        cfg_rd = ~w;
        cfg_wr = w;
        idx = i;
        be = b;
        wd = d;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        chk({31'h0, ack}, 32'h1);
    endtask
    task rdc(input logic [5:0] i, input logic [31:0] exp);
        acc(1'b0, i, 4'h0, 32'h0);
        chk(rdat, exp);
    endtask
    task load(input logic pres);
        @(posedge clk);
        #1;
        ld = 1'b1;
        eep = pres;
        @(posedge clk);
        #1;
        ld = 1'b0;
    endtask
    // error events; enables sampled the cycle after
    task errp();
        @(posedge clk);
        #1;
        {ape, tpe, scs} = 3'b111;
        @(posedge clk);
        #1;
        {ape, tpe, scs} = 3'b000;
    endtask
    task gates(input logic [31:0] exp);
        repeat (2) @(posedge clk);
        #1;
        chk({26'h0, ioe, meme, mreq, wie, fbbd, scc | ads}, exp);
    endtask
    task results();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        rdc(CFG_IDENT_IDX, {DEVICE_DEFAULT, VENDOR_DEFAULT});
        rdc(CFG_CMD_IDX, 32'h0);
        eev = 16'h5a3c;
        eed = 16'hc3a5;
        load(1'b1);
        rdc(CFG_IDENT_IDX, 32'hc3a5_5a3c);
        load(1'b0);
        rdc(CFG_IDENT_IDX, {DEVICE_DEFAULT, VENDOR_DEFAULT});
        acc(1'b1, CFG_CMD_IDX, 4'hf, 32'hffff_ffff);
        rdc(CFG_CMD_IDX, 32'h0157);
        gates(32'h3c);
        fbb = 1'b1;
        rdc(CFG_CMD_IDX, 32'h0157);
        acc(1'b1, CFG_CMD_IDX, 4'h3, 32'h0000_0200);
        rdc(CFG_CMD_IDX, 32'h0200);
        gates(32'h02);
        acc(1'b1, CFG_CMD_IDX, 4'h1, 32'h0000_ffff);
        rdc(CFG_CMD_IDX, 32'h0257);
        acc(1'b1, CFG_CMD_IDX, 4'h2, 32'h0000_ffff);
        rdc(CFG_CMD_IDX, 32'h0357);
        fbb = 1'b0;
        gates(32'h3c);
        mw = 1'b0;
        gates(32'h34);
        mw = 1'b1;
        errp();
        chk({30'h0, s_oe, p_oe}, 32'h0);
        chk({30'h0, s_out, p_out}, 32'h0);
        chk({30'h0, scc, ads}, 32'h0);
        mact = 1'b1;
        hlow = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({31'h0, mps}, 32'h1);
        hlow = 1'b0;
        rdc(6'h05, 32'h0);
        acc(1'b1, 6'h05, 4'hf, 32'h0);
        rdc(CFG_CMD_IDX, 32'h0157);
        acc(1'b1, CFG_CMD_IDX, 4'h3, 32'h0);
        gates(32'h00);
        errp();
        chk({30'h0, s_oe, p_oe}, 32'h3);
        hlow = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({31'h0, mps}, 32'h0);
        hlow = 1'b0;
        acc(1'b1, CFG_CMD_IDX, 4'h3, 32'hffff);
        srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        fbb = 1'b1;
        rdc(CFG_CMD_IDX, 32'h0);
        results();
    end
endmodule // testbench
